// ==== verilog/qcnt_pkg.sv ====
// Package for the 32-bit two-phase encoder counter.
// Assumes one 100 MHz clock and a plain strobe-driven register port.
package qcnt_pkg;

	// Register byte addresses
	localparam logic [7:0] QCNT_CH1_CTRL_ADDR = 8'h00;
	localparam logic [7:0] QCNT_CH2_CTRL_ADDR = 8'h04;
	localparam logic [7:0] QCNT_LINK_ADDR     = 8'h08;
	localparam logic [7:0] QCNT_CH1_CNT_ADDR  = 8'h10;
	localparam logic [7:0] QCNT_CH1_CAPA_ADDR = 8'h14;
	localparam logic [7:0] QCNT_CH1_CAPB_ADDR = 8'h18;
	localparam logic [7:0] QCNT_CH2_CNT_ADDR  = 8'h20;
	localparam logic [7:0] QCNT_CH2_CAPA_ADDR = 8'h24;
	localparam logic [7:0] QCNT_CH2_CAPB_ADDR = 8'h28;
	localparam logic [7:0] QCNT_LONG_CNT_ADDR = 8'h30;
	localparam logic [7:0] QCNT_LONG_CAPA_ADDR = 8'h34;
	localparam logic [7:0] QCNT_LONG_CAPB_ADDR = 8'h38;

	// Channel control field positions
	localparam int QCNT_F_EN    = 0;
	localparam int QCNT_F_PHASE = 1;
	localparam int QCNT_F_PAIR  = 2;
	localparam int QCNT_F_INVA  = 3;
	localparam int QCNT_F_INVB  = 4;
	localparam int QCNT_F_CMP   = 5;
	localparam int QCNT_F_CAP   = 6;
	localparam int QCNT_CTRL_W  = 7;

	// Synchroniser lane positions
	localparam int QCNT_L_A1  = 0;
	localparam int QCNT_L_B1  = 1;
	localparam int QCNT_L_A2  = 2;
	localparam int QCNT_L_B2  = 3;
	localparam int QCNT_L_CP1 = 4;
	localparam int QCNT_L_CP2 = 5;
	localparam int QCNT_LANES = 6;

	// Reset values and counter limits
	localparam logic [QCNT_CTRL_W-1:0] QCNT_CTRL_RST = 7'h00;
	localparam logic [15:0] QCNT_HALF_MAX  = 16'hFFFF;
	localparam logic [15:0] QCNT_HALF_ZERO = 16'h0000;
	localparam logic [15:0] QCNT_HALF_ONE  = 16'h0001;
	localparam logic [31:0] QCNT_WORD_ZERO = 32'h0000_0000;
	localparam logic [31:0] QCNT_WORD_ONE  = 32'h0000_0001;

endpackage : qcnt_pkg

// ==== verilog/qcnt_counter.sv ====
// Two-phase encoder counter: two 16-bit channels, linkable into one 32-bit timer.
// Assumes encoder and index pins are asynchronous inputs sampled on ref_clk.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none

module qcnt_counter
	import qcnt_pkg::*;
(
	input  wire logic        ref_clk,                 // 100 MHz clock
	input  wire logic        srst,                    // Synchronous reset, high
	input  wire logic [7:0]  reg_addr,                // Register byte address
	input  wire logic [31:0] reg_wdata,               // Write data
	input  wire logic        reg_wr,                  // Write strobe
	input  wire logic        reg_rd,                  // Read strobe
	output logic      [31:0] reg_rdata,               // Read data, cycle after strobe
	input  wire logic        phase_a_pin_first,       // A phase, first pair
	input  wire logic        phase_b_pin_first,       // B phase, first pair
	input  wire logic        phase_a_pin_second,      // A phase, second pair
	input  wire logic        phase_b_pin_second,      // B phase, second pair
	input  wire logic        ch_one_capture_a_pin,    // Index pulse, linked mode
	input  wire logic        ch_two_capture_a_pin,    // Index pulse, unlinked mode
	output logic             ch_one_capture_b_pin_o,  // Compare toggle output
	output logic             ch_one_capture_b_pin_oe, // Drive enable of toggle pin
	output logic             event_link_ch1,          // Channel one capture/compare pulse
	output logic             event_link_ch2           // Channel two capture pulse
);

	// All state in one record
	typedef struct packed {
		logic [QCNT_CTRL_W-1:0] ctrl1;
		logic [QCNT_CTRL_W-1:0] ctrl2;
		logic                   link;
		logic [15:0]            cnt_hi;
		logic [15:0]            cnt_lo;
		logic [31:0]            capa;
		logic [31:0]            capb;
		logic [QCNT_LANES-1:0]  sync1;
		logic [QCNT_LANES-1:0]  sync2;
		logic [QCNT_LANES-1:0]  prev;
		logic                   pin_b;
		logic [31:0]            rdata;
		logic                   ev1;
		logic                   ev2;
	} qcnt_state_t;

	qcnt_state_t st_reg;
	qcnt_state_t st_next;

	logic [QCNT_CTRL_W-1:0] act_ctrl;
	logic                   a_now, b_now, a_old, b_old, a_edge, b_edge;
	logic                   step_up, step_dn, carry_up, carry_dn, hi_en;
	logic                   cap1_rise, cap2_rise, cap_fire, cmp_hit;
	logic [QCNT_LANES-1:0]  pins_in;
	logic [31:0]            cnt_word;

	assign pins_in = {ch_two_capture_a_pin, ch_one_capture_a_pin, phase_b_pin_second,
		phase_a_pin_second, phase_b_pin_first, phase_a_pin_first};
	assign cnt_word = {st_reg.cnt_hi, st_reg.cnt_lo};

	// Phase decode; channel two controls are ignored while linked
	always_comb begin
		act_ctrl = st_reg.link ? st_reg.ctrl1 : st_reg.ctrl2;
		// One select bit keeps A and B in the same pin pair
		a_now = (act_ctrl[QCNT_F_PAIR] ? st_reg.sync2[QCNT_L_A2] : st_reg.sync2[QCNT_L_A1])
			^ act_ctrl[QCNT_F_INVA];
		b_now = (act_ctrl[QCNT_F_PAIR] ? st_reg.sync2[QCNT_L_B2] : st_reg.sync2[QCNT_L_B1])
			^ act_ctrl[QCNT_F_INVB];
		a_old = (act_ctrl[QCNT_F_PAIR] ? st_reg.prev[QCNT_L_A2] : st_reg.prev[QCNT_L_A1])
			^ act_ctrl[QCNT_F_INVA];
		b_old = (act_ctrl[QCNT_F_PAIR] ? st_reg.prev[QCNT_L_B2] : st_reg.prev[QCNT_L_B1])
			^ act_ctrl[QCNT_F_INVB];
		a_edge = a_now != a_old;
		b_edge = b_now != b_old;
		// Both phases moving in one cycle is ambiguous and counts nothing
		step_up = act_ctrl[QCNT_F_EN] && act_ctrl[QCNT_F_PHASE] && ((b_edge && !a_edge && (a_now == b_now))
			|| (a_edge && !b_edge && (a_now != b_now)));
		step_dn = act_ctrl[QCNT_F_EN] && act_ctrl[QCNT_F_PHASE] && ((b_edge && !a_edge && (a_now != b_now))
			|| (a_edge && !b_edge && (a_now == b_now)));
		carry_up = step_up && (st_reg.cnt_lo == QCNT_HALF_MAX);
		carry_dn = step_dn && (st_reg.cnt_lo == QCNT_HALF_ZERO);
		hi_en = st_reg.link || st_reg.ctrl1[QCNT_F_EN];
		cap1_rise = st_reg.sync2[QCNT_L_CP1] && !st_reg.prev[QCNT_L_CP1];
		cap2_rise = st_reg.sync2[QCNT_L_CP2] && !st_reg.prev[QCNT_L_CP2];
		// Channel two capture source is dead while linked
		cap_fire = st_reg.link ? (cap1_rise && st_reg.ctrl1[QCNT_F_CAP])
			: (cap2_rise && st_reg.ctrl2[QCNT_F_CAP]);
	end

	// Next state: synchroniser, bus writes, counting, compare, capture
	always_comb begin
		st_next = st_reg;
		cmp_hit = 1'b0;
		// First stage feeds only the second stage
		st_next.sync1 = pins_in;
		st_next.sync2 = st_reg.sync1;
		st_next.prev  = st_reg.sync2;
		st_next.ev1   = 1'b0;
		st_next.ev2   = 1'b0;
		// Software writes; blocked registers swallow the write
		if (reg_wr) begin
			case (reg_addr)
				QCNT_CH1_CTRL_ADDR: st_next.ctrl1 = reg_wdata[QCNT_CTRL_W-1:0];
				QCNT_CH2_CTRL_ADDR: st_next.ctrl2 = reg_wdata[QCNT_CTRL_W-1:0];
				QCNT_LINK_ADDR:     st_next.link = reg_wdata[0];
				QCNT_CH1_CNT_ADDR:  if (!st_reg.link) st_next.cnt_hi = reg_wdata[15:0];
				QCNT_CH1_CAPA_ADDR: if (!st_reg.link) st_next.capa[31:16] = reg_wdata[15:0];
				QCNT_CH1_CAPB_ADDR: if (!st_reg.link) st_next.capb[31:16] = reg_wdata[15:0];
				QCNT_CH2_CNT_ADDR:  if (!st_reg.link) st_next.cnt_lo = reg_wdata[15:0];
				QCNT_CH2_CAPA_ADDR: if (!st_reg.link) st_next.capa[15:0] = reg_wdata[15:0];
				QCNT_CH2_CAPB_ADDR: if (!st_reg.link) st_next.capb[15:0] = reg_wdata[15:0];
				QCNT_LONG_CNT_ADDR: if (st_reg.link) {st_next.cnt_hi, st_next.cnt_lo} = reg_wdata;
				QCNT_LONG_CAPA_ADDR: if (st_reg.link) st_next.capa = reg_wdata;
				QCNT_LONG_CAPB_ADDR: if (st_reg.link) st_next.capb = reg_wdata;
				default: ;
			endcase
		end
		// Counting beats a same-cycle write to the lower half; the upper half yields only on a carry or borrow; natural wrap at both ends
		if (step_up) begin
			st_next.cnt_lo = st_reg.cnt_lo + QCNT_HALF_ONE;
		end else if (step_dn) begin
			st_next.cnt_lo = st_reg.cnt_lo - QCNT_HALF_ONE;
		end
		if (hi_en && carry_up) begin
			st_next.cnt_hi = st_reg.cnt_hi + QCNT_HALF_ONE;
		end else if (hi_en && carry_dn) begin
			st_next.cnt_hi = st_reg.cnt_hi - QCNT_HALF_ONE;
		end
		// Compare on the step that lands on the compare value
		if (st_reg.ctrl1[QCNT_F_CMP]) begin
			if (st_reg.link) begin
				cmp_hit = (step_up || step_dn) && ({st_next.cnt_hi, st_next.cnt_lo} == st_reg.capb);
			end else begin
				cmp_hit = (st_next.cnt_hi != st_reg.cnt_hi) && (st_next.cnt_hi == st_reg.capb[31:16]);
			end
		end
		if (cmp_hit) begin
			st_next.pin_b = !st_reg.pin_b;
			st_next.ev1 = 1'b1;
		end
		// Index capture wins over counting and writes
		if (cap_fire) begin
			st_next.capa = cnt_word;
			st_next.cnt_hi = QCNT_HALF_ZERO;
			st_next.cnt_lo = QCNT_HALF_ZERO;
			// A compare pulse in the same cycle must survive the capture
			st_next.ev1 = st_next.ev1 || st_reg.link;
			st_next.ev2 = !st_reg.link;
		end
		// Read data valid only in the cycle after the strobe
		st_next.rdata = QCNT_WORD_ZERO;
		if (reg_rd) begin
			case (reg_addr)
				QCNT_CH1_CTRL_ADDR: st_next.rdata = {25'h000_0000, st_reg.ctrl1};
				QCNT_CH2_CTRL_ADDR: st_next.rdata = {25'h000_0000, st_reg.ctrl2};
				QCNT_LINK_ADDR:     st_next.rdata = {31'h0000_0000, st_reg.link};
				QCNT_CH1_CNT_ADDR:  if (!st_reg.link) st_next.rdata = {16'h0000, st_reg.cnt_hi};
				QCNT_CH1_CAPA_ADDR: if (!st_reg.link) st_next.rdata = {16'h0000, st_reg.capa[31:16]};
				QCNT_CH1_CAPB_ADDR: if (!st_reg.link) st_next.rdata = {16'h0000, st_reg.capb[31:16]};
				QCNT_CH2_CNT_ADDR:  if (!st_reg.link) st_next.rdata = {16'h0000, st_reg.cnt_lo};
				QCNT_CH2_CAPA_ADDR: if (!st_reg.link) st_next.rdata = {16'h0000, st_reg.capa[15:0]};
				QCNT_CH2_CAPB_ADDR: if (!st_reg.link) st_next.rdata = {16'h0000, st_reg.capb[15:0]};
				QCNT_LONG_CNT_ADDR: if (st_reg.link) st_next.rdata = cnt_word;
				QCNT_LONG_CAPA_ADDR: if (st_reg.link) st_next.rdata = st_reg.capa;
				QCNT_LONG_CAPB_ADDR: if (st_reg.link) st_next.rdata = st_reg.capb;
				default: st_next.rdata = QCNT_WORD_ZERO;
			endcase
		end
	end

	// State register; toggle pin starts low
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_reg <= '0;
			st_reg.ctrl1 <= QCNT_CTRL_RST;
			st_reg.ctrl2 <= QCNT_CTRL_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata               = st_reg.rdata;
	assign ch_one_capture_b_pin_o  = st_reg.pin_b;
	assign ch_one_capture_b_pin_oe = st_reg.ctrl1[QCNT_F_CMP];
	assign event_link_ch1          = st_reg.ev1;
	assign event_link_ch2          = st_reg.ev2;

	// Checks
	a_up_step: assert property (@(posedge ref_clk) disable iff (srst)
		(st_reg.link && step_up && !cap_fire && !reg_wr) |=> (cnt_word == $past(cnt_word) + QCNT_WORD_ONE))
		else $error("linked counter missed an up step");
	a_down_step: assert property (@(posedge ref_clk) disable iff (srst)
		(st_reg.link && step_dn && !cap_fire && !reg_wr) |=> (cnt_word == $past(cnt_word) - QCNT_WORD_ONE))
		else $error("linked counter missed a down step");
	a_index_capture: assert property (@(posedge ref_clk) disable iff (srst)
		(st_reg.link && cap_fire) |=> (st_reg.capa == $past(cnt_word)) && (cnt_word == QCNT_WORD_ZERO))
		else $error("index capture or clear wrong");
	a_half_blocked: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_rd && st_reg.link && (reg_addr == QCNT_CH2_CNT_ADDR)) |=> (reg_rdata == QCNT_WORD_ZERO))
		else $error("half counter readable while linked");
	a_ch2_silent: assert property (@(posedge ref_clk) disable iff (srst)
		$past(st_reg.link) |-> !event_link_ch2)
		else $error("channel two event while linked");
	a_toggle_pin: assert property (@(posedge ref_clk) disable iff (srst)
		cmp_hit |=> (ch_one_capture_b_pin_o != $past(ch_one_capture_b_pin_o)) && event_link_ch1)
		else $error("compare did not toggle pin");
	a_cascade_clear: assert property (@(posedge ref_clk) disable iff (srst)
		(!st_reg.link && cap_fire) |=> (cnt_word == QCNT_WORD_ZERO) ##0 event_link_ch2)
		else $error("unlinked index did not clear both");
	a_carry_up: assert property (@(posedge ref_clk) disable iff (srst)
		(!st_reg.link && st_reg.ctrl1[QCNT_F_EN] && carry_up && !cap_fire && !reg_wr)
		|=> (st_reg.cnt_hi == $past(st_reg.cnt_hi) + QCNT_HALF_ONE) && (st_reg.cnt_lo == QCNT_HALF_ZERO))
		else $error("channel one missed overflow count");
	a_long_blocked: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_rd && !st_reg.link && (reg_addr == QCNT_LONG_CNT_ADDR)) |=> (reg_rdata == QCNT_WORD_ZERO))
		else $error("long counter readable while unlinked");
	a_single_step: assert property (@(posedge ref_clk) disable iff (srst)
		!(step_up && step_dn))
		else $error("up and down step in one cycle");
	a_both_edges: assert property (@(posedge ref_clk) disable iff (srst)
		(a_edge && b_edge) |-> !(step_up || step_dn))
		else $error("step counted on a double edge");
	a_wrap_down: assert property (@(posedge ref_clk) disable iff (srst)
		(st_reg.link && step_dn && (cnt_word == QCNT_WORD_ZERO) && !cap_fire && !reg_wr)
		|=> (cnt_word == ~QCNT_WORD_ZERO))
		else $error("counter did not wrap below zero");
	a_wrap_up: assert property (@(posedge ref_clk) disable iff (srst)
		(st_reg.link && step_up && (cnt_word == ~QCNT_WORD_ZERO) && !cap_fire)
		|=> (cnt_word == QCNT_WORD_ZERO))
		else $error("counter did not wrap above all ones");

	// Linking and control selection
	a_link_follows: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_wr && (reg_addr == QCNT_LINK_ADDR)) |=> (st_reg.link == $past(reg_wdata[0])))
		else $error("link bit did not take the write");
	a_linked_carry: assert property (@(posedge ref_clk) disable iff (srst)
		(st_reg.link && carry_up && !cap_fire)
		|=> (st_reg.cnt_hi == $past(st_reg.cnt_hi) + QCNT_HALF_ONE))
		else $error("linked upper half missed a carry");
	a_ch2_ignored: assert property (@(posedge ref_clk) disable iff (srst)
		(st_reg.link && !(st_reg.ctrl1[QCNT_F_EN] && st_reg.ctrl1[QCNT_F_PHASE])) |-> !(step_up || step_dn))
		else $error("linked counter moved without channel one enabled");
	a_pair_lock: assert property (@(posedge ref_clk) disable iff (srst)
		(st_reg.link && !st_reg.ctrl1[QCNT_F_PAIR] && (st_reg.sync2[QCNT_L_A1] == st_reg.prev[QCNT_L_A1])
		&& (st_reg.sync2[QCNT_L_B1] == st_reg.prev[QCNT_L_B1])) |-> !(step_up || step_dn))
		else $error("unselected pin pair moved the count");

	// Register port fencing; a blocked write must leave the register untouched
	a_half_write: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_wr && st_reg.link && (reg_addr == QCNT_CH1_CAPB_ADDR)) |=> $stable(st_reg.capb))
		else $error("half capture B written while linked");
	a_long_write: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_wr && !st_reg.link && (reg_addr == QCNT_LONG_CAPA_ADDR) && !cap_fire) |=> $stable(st_reg.capa))
		else $error("long capture A written while unlinked");
	a_rdata_idle: assert property (@(posedge ref_clk) disable iff (srst)
		!reg_rd |=> (reg_rdata == QCNT_WORD_ZERO))
		else $error("read data outside its cycle");

	// Unlinked cascade and capture routing
	a_carry_down: assert property (@(posedge ref_clk) disable iff (srst)
		(!st_reg.link && st_reg.ctrl1[QCNT_F_EN] && carry_dn && !cap_fire && !reg_wr)
		|=> (st_reg.cnt_hi == $past(st_reg.cnt_hi) - QCNT_HALF_ONE) && (st_reg.cnt_lo == QCNT_HALF_MAX))
		else $error("channel one missed underflow count");
	a_hi_frozen: assert property (@(posedge ref_clk) disable iff (srst)
		(!st_reg.link && !st_reg.ctrl1[QCNT_F_EN] && !cap_fire && !reg_wr)
		|=> $stable(st_reg.cnt_hi))
		else $error("channel one moved while not enabled");
	a_ch2_dead: assert property (@(posedge ref_clk) disable iff (srst)
		(st_reg.link && !cap1_rise) |-> !cap_fire)
		else $error("channel two index acted while linked");
	a_linked_event: assert property (@(posedge ref_clk) disable iff (srst)
		(st_reg.link && cap_fire) |=> event_link_ch1 && !event_link_ch2)
		else $error("linked capture gave the wrong event");

	// Toggle pin: moves only on a compare, low out of reset
	a_pin_quiet: assert property (@(posedge ref_clk) disable iff (srst)
		!cmp_hit |=> $stable(ch_one_capture_b_pin_o))
		else $error("toggle pin moved without a compare");
	a_reset_state: assert property (@(posedge ref_clk)
		srst |=> !ch_one_capture_b_pin_o && (reg_rdata == QCNT_WORD_ZERO)
		&& !event_link_ch1 && !event_link_ch2)
		else $error("outputs not cleared by reset");

	c_linked_up:   cover property (@(posedge ref_clk) disable iff (srst) st_reg.link && step_up);
	c_linked_cap:  cover property (@(posedge ref_clk) disable iff (srst) st_reg.link && cap_fire);
	c_cascade_dn:  cover property (@(posedge ref_clk) disable iff (srst) !st_reg.link && carry_dn && hi_en);
	c_compare_hit: cover property (@(posedge ref_clk) disable iff (srst) cmp_hit);
	c_cascade_cap: cover property (@(posedge ref_clk) disable iff (srst) !st_reg.link && cap_fire);

endmodule : qcnt_counter

`default_nettype wire

// ==== verification/qcnt_encoder_model.sv ====
// Two-phase encoder with index pulses, standing outside the counter.
// Assumes the caller invokes its tasks from a process clocked by ref_clk.
`timescale 1ns/1ps
`default_nettype none

module qcnt_encoder_model #(
	parameter int GAP = 4
) (
	input  wire logic ref_clk, // Sampling clock of the counter
	output logic      a1,      // A phase, first pair
	output logic      b1,      // B phase, first pair
	output logic      a2,      // A phase, second pair
	output logic      b2,      // B phase, second pair
	output logic      idx1,    // Index for the linked counter
	output logic      idx2     // Index for the unlinked counter
);
	logic [1:0] st1 = 2'h0;
	logic [1:0] st2 = 2'h0;
	initial {a1, b1, a2, b2, idx1, idx2} = 6'h00;

	// Up walks 00,10,11,01 on (A,B); each pair keeps its own state so a pair swap makes no edge
	task automatic step(input logic sel, input logic inv, input logic up);
		logic [1:0] s;
		s = sel ? st2 : st1;
		s = up ? s + 2'h1 : s - 2'h1;
		@(posedge ref_clk);
		if (sel) begin
			st2 = s;
			a2 <= (s[0] ^ s[1]) ^ inv;
			b2 <= s[1] ^ inv;
		end else begin
			st1 = s;
			a1 <= s[0] ^ s[1];
			b1 <= s[1];
		end
		// Spacing keeps each edge apart so the counter sees one step at a time
		repeat (GAP) @(posedge ref_clk);
	endtask : step

	// Index pulse, held a few cycles so the synchroniser catches it
	task automatic pulse(input logic which);
		@(posedge ref_clk);
		if (which) idx2 <= 1'b1;
		else idx1 <= 1'b1;
		repeat (3) @(posedge ref_clk);
		{idx1, idx2} <= 2'h0;
		repeat (GAP) @(posedge ref_clk);
	endtask : pulse

	// Moves both second-pair pins at once to their idle level under a new inversion.
	// Call it while the other pair is selected; a double edge would count nothing anyway.
	task automatic park(input logic inv);
		@(posedge ref_clk);
		a2 <= (st2[0] ^ st2[1]) ^ inv;
		b2 <= st2[1] ^ inv;
		repeat (GAP) @(posedge ref_clk);
	endtask : park
endmodule : qcnt_encoder_model
`default_nettype wire

// ==== verification/quadrature_counter_32bit_test.sv ====
// Self-checking bench for the two-phase encoder counter.
// Assumes the encoder model file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none

module quadrature_counter_32bit_test;
	import qcnt_pkg::*;
	logic        ref_clk, srst, reg_wr, reg_rd, rd_seen, sel, inv;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, exp_v, seed;
	logic        a1, b1, a2, b2, idx1, idx2, pin_o, pin_oe, ev1, ev2;
	logic [31:0] exp_q[$];
	int          num_errors, cmp_count, cyc, n, ev1_cnt, ev2_cnt;

	qcnt_counter uut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_a_pin_first(a1),
		.phase_b_pin_first(b1), .phase_a_pin_second(a2), .phase_b_pin_second(b2),
		.ch_one_capture_a_pin(idx1), .ch_two_capture_a_pin(idx2), .ch_one_capture_b_pin_o(pin_o),
		.ch_one_capture_b_pin_oe(pin_oe), .event_link_ch1(ev1), .event_link_ch2(ev2));
	qcnt_encoder_model #(.GAP(4)) enc (.ref_clk(ref_clk), .a1(a1), .b1(b1), .a2(a2), .b2(b2),
		.idx1(idx1), .idx2(idx2));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic summarize();
		if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize

	// Bus cycles: one strobe cycle each, the read note queued for the monitor
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask : rd

	// Steps, then lets the synchroniser and counter settle before anyone reads
	task automatic mv(input logic up, input int k);
		repeat (k) enc.step(sel, inv, up);
		repeat (6) @(posedge ref_clk);
	endtask : mv

	// Read data stand only in the cycle after the strobe, so compare exactly there
	always @(posedge ref_clk) begin
		if (rd_seen === 1'b1) begin
			exp_v = exp_q.pop_front();
			chk("reg_rdata", exp_v, reg_rdata);
		end
		rd_seen <= reg_rd;
		// Event pulses last one cycle, so they are counted on every edge
		if (ev1 === 1'b1) ev1_cnt++;
		if (ev2 === 1'b1) ev2_cnt++;
	end

	// Hang guard, far above the expected run length
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			summarize();
		end
	end

	initial begin
		{srst, reg_wr, reg_rd, sel, inv} = 5'h10;
		{reg_addr, reg_wdata} = 40'h00_0000_0000;
		seed = 32'h0000_0015;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		rd(QCNT_CH1_CTRL_ADDR, 32'h0000_0000);
		rd(QCNT_LONG_CNT_ADDR, 32'h0000_0000);
		rd(8'hFC, 32'h0000_0000);
		// Linked: ch1 EN, PHASE, CAP; counters still hold their reset zeros
		wr(QCNT_CH1_CTRL_ADDR, 32'h0000_0043);
		wr(QCNT_LINK_ADDR, 32'h0000_0001);
		rd(QCNT_LINK_ADDR, 32'h0000_0001);
		seed = xs(seed);
		n = int'(seed[2:0]) + 2;
		mv(1'b1, n);
		rd(QCNT_LONG_CNT_ADDR, 32'(n));
		rd(QCNT_CH1_CNT_ADDR, 32'h0000_0000);
		mv(1'b0, n + 1);
		rd(QCNT_LONG_CNT_ADDR, 32'hFFFF_FFFF);
		mv(1'b1, 1);
		rd(QCNT_LONG_CNT_ADDR, 32'h0000_0000);
		mv(1'b1, n);
		enc.pulse(1'b0);
		rd(QCNT_LONG_CAPA_ADDR, 32'(n));
		rd(QCNT_LONG_CNT_ADDR, 32'h0000_0000);
		// Second pin pair, both phases inverted; its pins first go to the inverted idle level
		enc.park(1'b1);
		wr(QCNT_CH1_CTRL_ADDR, 32'h0000_005F);
		{sel, inv} = 2'h3;
		mv(1'b1, 3);
		rd(QCNT_LONG_CNT_ADDR, 32'h0000_0003);
		// Channel two index is dead while linked
		enc.pulse(1'b1);
		rd(QCNT_LONG_CNT_ADDR, 32'h0000_0003);
		// Compare toggle; CMP kept off until now so earlier passes over zero stay quiet
		{sel, inv} = 2'h0;
		wr(QCNT_LONG_CAPB_ADDR, 32'h0000_0005);
		wr(QCNT_CH1_CAPB_ADDR, 32'h0000_FFFF);
		rd(QCNT_LONG_CAPB_ADDR, 32'h0000_0005);
		wr(QCNT_CH1_CTRL_ADDR, 32'h0000_0063);
		@(posedge ref_clk);
		chk("pin_oe", 32'h1, {31'h0, pin_oe});
		chk("pin_o", 32'h0, {31'h0, pin_o});
		mv(1'b1, 2);
		chk("pin_o", 32'h1, {31'h0, pin_o});
		mv(1'b0, 1);
		mv(1'b1, 1);
		chk("pin_o", 32'h0, {31'h0, pin_o});
		chk("ev1_count", 32'h0000_0003, 32'(ev1_cnt));
		// Unlinked: ch2 counts phases, ch1 follows its carries and borrows
		wr(QCNT_LINK_ADDR, 32'h0000_0000);
		wr(QCNT_CH1_CTRL_ADDR, 32'h0000_0001);
		wr(QCNT_CH2_CTRL_ADDR, 32'h0000_0043);
		wr(QCNT_CH1_CNT_ADDR, 32'h0000_0000);
		wr(QCNT_CH2_CNT_ADDR, 32'h0000_FFFF);
		wr(QCNT_LONG_CAPA_ADDR, 32'hFFFF_FFFF);
		rd(QCNT_CH2_CAPA_ADDR, 32'h0000_0006);
		rd(QCNT_LONG_CNT_ADDR, 32'h0000_0000);
		mv(1'b1, 1);
		rd(QCNT_CH2_CNT_ADDR, 32'h0000_0000);
		rd(QCNT_CH1_CNT_ADDR, 32'h0000_0001);
		mv(1'b0, 1);
		rd(QCNT_CH2_CNT_ADDR, 32'h0000_FFFF);
		rd(QCNT_CH1_CNT_ADDR, 32'h0000_0000);
		mv(1'b1, 2);
		enc.pulse(1'b1);
		rd(QCNT_CH1_CNT_ADDR, 32'h0000_0000);
		rd(QCNT_CH2_CNT_ADDR, 32'h0000_0000);
		rd(QCNT_CH1_CAPA_ADDR, 32'h0000_0001);
		rd(QCNT_CH2_CAPA_ADDR, 32'h0000_0001);
		// Unlinked compare: upper half stepping onto capture B's upper half toggles the pin
		wr(QCNT_CH1_CAPB_ADDR, 32'h0000_0001);
		wr(QCNT_CH1_CTRL_ADDR, 32'h0000_0021);
		wr(QCNT_CH2_CNT_ADDR, 32'h0000_FFFF);
		mv(1'b1, 1);
		chk("pin_o", 32'h0000_0001, {31'h0, pin_o});
		chk("ev1_count", 32'h0000_0004, 32'(ev1_cnt));
		chk("ev2_count", 32'h0000_0001, 32'(ev2_cnt));
		repeat (4) @(posedge ref_clk);
		summarize();
	end
endmodule : quadrature_counter_32bit_test
`default_nettype wire
